// File: rtl/afc_encoder.sv
`timescale 1ns/1ps
// Saturates a raw conversion value and encodes it as Gray or two's complement.
module afc_encoder
   import afc_pkg::*;
(
   input wire logic signed [RAW_W-1:0] raw_value,
   input wire logic gray_mode,
   output logic [SAMPLE_W-1:0] code_word,
   output logic over_range
);

   // Clamped signed value and its offset-binary form.
   logic signed [RAW_W-1:0] clamped;
   logic [SAMPLE_W-1:0] offset_bin;

   // Clamp to full scale, flag over-range, then pick the output format.
   always_comb begin
      over_range = 1'b0;
      clamped = raw_value;
      if (raw_value > CODE_MAX) begin
         over_range = 1'b1; // [R05]
         clamped = CODE_MAX;
      end else if (raw_value < CODE_MIN) begin
         over_range = 1'b1; // [R05]
         clamped = CODE_MIN;
      end
      // Offset binary adds half scale, which is just the sign bit inverted.
      offset_bin = {~clamped[SAMPLE_W-1], clamped[SAMPLE_W-2:0]}; // [R04]
      if (gray_mode) begin
         code_word = offset_bin ^ (offset_bin >> 1); // [R01] [R04]
      end else begin
         code_word = clamped[SAMPLE_W-1:0]; // [R01] [R03]
      end
   end

endmodule : afc_encoder

// File: rtl/afc_formatter.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01: Format pin high gives Gray, low twos.
// R02: Twelve-bit parallel bus with high-impedance release.
// R03: Twos complement codes span -2048 to +2047.
// R04: Gray of offset binary; zero is 0xC00.
// R05: Over-range flag set, word saturates full scale.
// R06: Flag shares the 8.5-cycle pipeline with data.
// R07: Outputs change on strobe fall, latched on rise.
// R08: Power-down releases bus and flag, later redriven.
// R09: Sample on falling edge; output 8.5 later.
// R10: Power-down high also releases the strobe.
// R11: Capture side treats flagged words as saturated.
module afc_formatter
   import afc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic link_clk,
   input wire logic signed [RAW_W-1:0] raw_value,
   input wire logic format_select,
   input wire logic power_down_input,
   output logic [SAMPLE_W-1:0] sample_bus,
   output logic sample_bus_oe,
   output logic over_range_flag,
   output logic over_range_flag_oe,
   output logic data_valid_strobe,
   output logic data_valid_strobe_oe
);

   // ---------------- Link side ----------------

   // Reset released synchronously into the link domain.
   logic [1:0] link_rst_chain;
   logic link_rst_n;

   // Link reset bridge: asserted at once, released after two link edges.
   always_ff @(posedge link_clk or negedge arst_n) begin
      if (!arst_n) begin
         link_rst_chain <= 2'h0;
      end else begin
         link_rst_chain <= {link_rst_chain[0], 1'b1};
      end
   end
   assign link_rst_n = link_rst_chain[1];

   // Control pins, settled in the link domain where the capture side drives them.
   logic [1:0] link_pins;
   logic link_gray;
   logic link_pd;
   logic [1:0] next_link_ctrl;
   logic [1:0] link_ctrl;

   // The pins are asynchronous to every clock, so they pass two flops first.
   afc_sync #(.WIDTH(2)) u_pin_sync (
      .clk(link_clk),
      .rst_n(link_rst_n),
      .async_in({power_down_input, format_select}),
      .sync_out(link_pins)
   );
   assign link_gray = link_pins[0];
   assign link_pd = link_pins[1];

   // Next value of the registered link controls.
   always_comb begin
      next_link_ctrl = {link_pd, link_gray};
   end

   // Registered link controls, the only signals handed to the sample domain.
   always_ff @(posedge link_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         link_ctrl <= 2'h0;
      end else begin
         link_ctrl <= next_link_ctrl;
      end
   end

   // ---------------- Sample clock side ----------------

   // Controls carried across as levels by a second synchroniser.
   // Each bit is an independent level, so a one-cycle skew between them only delays
   // one control by a cycle and never forms a combination that the logic acts on wrongly.
   logic [1:0] core_ctrl;
   logic fmt_gray; // High selects Gray output.
   logic pd_active; // High while power-down is requested.

   afc_sync #(.WIDTH(2)) u_ctrl_sync (
      .clk(ref_clk),
      .rst_n(arst_n),
      .async_in(link_ctrl),
      .sync_out(core_ctrl)
   );
   assign fmt_gray = core_ctrl[0];
   assign pd_active = core_ctrl[1];

   // Falling-edge capture of the converter value; it comes from logic on this clock.
   logic signed [RAW_W-1:0] captured;
   logic signed [RAW_W-1:0] next_captured;

   // The capture simply follows the converter value.
   always_comb begin
      next_captured = raw_value;
   end

   // Sampling instant is the falling clock edge.
   always_ff @(negedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         captured <= '0;
      end else begin
         captured <= next_captured; // [R09]
      end
   end

   // Encoded form of the captured value.
   logic [SAMPLE_W-1:0] enc_word;
   logic enc_flag;

   afc_encoder u_encoder (
      .raw_value(captured),
      .gray_mode(fmt_gray),
      .code_word(enc_word),
      .over_range(enc_flag)
   );

   // Rising-edge pipeline; word and flag travel side by side.
   logic [SAMPLE_W-1:0] pipe_word [1:PIPE_STAGES];
   logic pipe_flag [1:PIPE_STAGES];
   logic [SAMPLE_W-1:0] next_pipe_word [1:PIPE_STAGES];
   logic next_pipe_flag [1:PIPE_STAGES];

   // Each stage takes the one before it; stage one takes the encoder.
   always_comb begin
      next_pipe_word[1] = enc_word;
      next_pipe_flag[1] = enc_flag; // [R06]
      for (int i = 2; i <= PIPE_STAGES; i++) begin
         next_pipe_word[i] = pipe_word[i-1];
         next_pipe_flag[i] = pipe_flag[i-1]; // [R06]
      end
   end

   // Pipeline registers, one per stage and entry.
   genvar gs;
   generate
      for (gs = 1; gs <= PIPE_STAGES; gs++) begin : g_stage
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               pipe_word[gs] <= WORD_RESET;
               pipe_flag[gs] <= 1'b0;
            end else begin
               pipe_word[gs] <= next_pipe_word[gs]; // [R09]
               pipe_flag[gs] <= next_pipe_flag[gs]; // [R06]
            end
         end
      end
   endgenerate

   // Last stage drives the pins; it updates on the rising clock edge, where the strobe falls.
   assign sample_bus = pipe_word[PIPE_STAGES]; // [R02] [R07]
   assign over_range_flag = pipe_flag[PIPE_STAGES]; // [R06] [R07]

   // Strobe built from two toggles so it is an inverted copy of the clock without gating it.
   logic rise_tog;
   logic fall_tog;
   logic next_rise_tog;
   logic next_fall_tog;

   // The rising toggle flips each rising edge; the falling one catches up on the falling edge.
   always_comb begin
      next_rise_tog = ~rise_tog;
      next_fall_tog = rise_tog;
   end

   // Rising-edge half of the strobe generator.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rise_tog <= 1'b0;
      end else begin
         rise_tog <= next_rise_tog;
      end
   end

   // Falling-edge half of the strobe generator.
   always_ff @(negedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         fall_tog <= 1'b0;
      end else begin
         fall_tog <= next_fall_tog;
      end
   end

   // Low from each rising edge (data changing), high from each falling edge (data stable).
   assign data_valid_strobe = (rise_tog == fall_tog); // [R07]

   // Output driver state: drive in normal mode, release in power-down.
   afc_bus_state_t bus_state;
   afc_bus_state_t next_bus_state;

   // Power-down moves the bus to release; its end returns it to drive.
   always_comb begin
      next_bus_state = bus_state;
      case (bus_state)
         AFC_DRIVE: begin
            if (pd_active) begin
               next_bus_state = AFC_RELEASE; // [R08]
            end
         end
         AFC_RELEASE: begin
            if (!pd_active) begin
               next_bus_state = AFC_DRIVE; // [R08]
            end
         end
         default: begin
            next_bus_state = AFC_RELEASE;
         end
      endcase
   end

   // Driver state register; reset holds the outputs released until the first rising edge after reset.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         bus_state <= AFC_RELEASE;
      end else begin
         bus_state <= next_bus_state;
      end
   end

   // All three pin groups share one enable.
   assign sample_bus_oe = (bus_state == AFC_DRIVE); // [R02] [R08]
   assign over_range_flag_oe = (bus_state == AFC_DRIVE); // [R08]
   assign data_valid_strobe_oe = (bus_state == AFC_DRIVE); // [R10]

   // ---------------- Checks ----------------

   // Output word equals the encoder result eight rising edges later.
   latency_word_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R09]
      ##8 (sample_bus == $past(pipe_word[1], 8)))
      else $error("sample word latency is not 8.5 cycles");

   // Flag follows its word through the same stages.
   flag_latency_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R06]
      ##8 (over_range_flag == $past(pipe_flag[1], 8)))
      else $error("over-range flag not aligned with data");

   // Zero input in Gray mode encodes to the half-scale Gray word.
   gray_zero_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R04]
      (fmt_gray && captured == '0) |-> ##1 (pipe_word[1] == GRAY_ZERO))
      else $error("Gray zero code wrong");

   // In-range two's complement passes the low twelve bits straight through.
   twos_pass_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R03]
      (!fmt_gray && captured <= CODE_MAX && captured >= CODE_MIN)
      |-> ##1 (pipe_word[1] == $past(captured[SAMPLE_W-1:0]) && !pipe_flag[1]))
      else $error("two's complement word wrong");

   // Positive over-range saturates and flags in either format.
   over_pos_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R05]
      (captured > CODE_MAX) |-> ##1 (pipe_flag[1] &&
      pipe_word[1] == ($past(fmt_gray) ? GRAY_POS_FULL : TWOS_POS_FULL)))
      else $error("positive over-range not saturated");

   // Negative over-range saturates and flags in either format.
   over_neg_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R05]
      (captured < CODE_MIN) |-> ##1 (pipe_flag[1] &&
      pipe_word[1] == ($past(fmt_gray) ? GRAY_NEG_FULL : TWOS_NEG_FULL)))
      else $error("negative over-range not saturated");

   // Power-down releases every output group by the next edge and keeps them released.
   pd_release_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R08]
      pd_active |-> ##1 (!sample_bus_oe && !over_range_flag_oe && !data_valid_strobe_oe))
      else $error("outputs driven during power-down");

   // Leaving power-down drives the bus and strobe outputs again one edge later.
   pd_resume_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R08]
      $fell(pd_active) |-> ##1 (sample_bus_oe && data_valid_strobe_oe))
      else $error("outputs not redriven after power-down");

   // The strobe is low in the half cycle after every rising edge, when the bus may change.
   strobe_low_a: assert property (@(negedge ref_clk) disable iff (!arst_n) // [R07]
      $changed(rise_tog) |-> !data_valid_strobe)
      else $error("strobe high while data changes");

   // The strobe is high just before every rising edge, so the capture side's rising
   // strobe edge always lands in the half cycle where the bus is settled.
   strobe_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R07]
      data_valid_strobe)
      else $error("strobe low while data is valid");

   // A flagged word on the pins is always one of the saturated full-scale codes.
   // The set holds for either format, so a format change in flight cannot trip it.
   flag_sat_word_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R05]
      over_range_flag |-> (sample_bus == TWOS_POS_FULL || sample_bus == TWOS_NEG_FULL ||
      sample_bus == GRAY_POS_FULL || sample_bus == GRAY_NEG_FULL))
      else $error("flagged word is not a full-scale code");

   // In Gray mode the top bit is the offset-binary top bit, the inverted sign.
   // This checks the half-scale offset without repeating the encoder's expression.
   gray_sign_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R04]
      (fmt_gray && captured <= CODE_MAX && captured >= CODE_MIN)
      |-> ##1 (!pipe_flag[1] && pipe_word[1][SAMPLE_W-1] != $past(captured[SAMPLE_W-1])))
      else $error("Gray top bit does not follow the offset sign");

   // Two edges without power-down leave every output group driven.
   pd_idle_drive_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R10]
      (!pd_active ##1 !pd_active) |-> (sample_bus_oe && over_range_flag_oe && data_valid_strobe_oe))
      else $error("outputs released without power-down");

endmodule : afc_formatter

// File: rtl/afc_pkg.sv
// Shared constants for the output code formatter.
package afc_pkg;

   // Width of the parallel sample bus.
   localparam int unsigned SAMPLE_W = 12;

   // Width of the raw converter value, one bit wider than the bus so over-range shows.
   localparam int unsigned RAW_W = 13;

   // Number of rising-edge stages after the falling-edge capture; with it they make 8.5 cycles.
   localparam int unsigned PIPE_STAGES = 9;

   // Depth of every two-flop synchroniser.
   localparam int unsigned SYNC_DEPTH = 2;

   // Largest and smallest in-range signed codes.
   localparam logic signed [RAW_W-1:0] CODE_MAX = 13'sh07FF;
   localparam logic signed [RAW_W-1:0] CODE_MIN = -13'sh0800;

   // Saturated two's complement words at the two full-scale ends.
   localparam logic [SAMPLE_W-1:0] TWOS_POS_FULL = 12'h7FF;
   localparam logic [SAMPLE_W-1:0] TWOS_NEG_FULL = 12'h800;

   // Gray words for zero input, positive full scale and negative full scale.
   localparam logic [SAMPLE_W-1:0] GRAY_ZERO = 12'hC00;
   localparam logic [SAMPLE_W-1:0] GRAY_POS_FULL = 12'h800;
   localparam logic [SAMPLE_W-1:0] GRAY_NEG_FULL = 12'h000;

   // Reset value of the pipeline words and of the output word.
   localparam logic [SAMPLE_W-1:0] WORD_RESET = 12'h000;

   // Output bus states.
   typedef enum logic [1:0] {
      AFC_DRIVE = 2'h1,
      AFC_RELEASE = 2'h2
   } afc_bus_state_t;

endpackage : afc_pkg

// File: rtl/afc_sync.sv
`timescale 1ns/1ps
// Two-flop level synchroniser, one chain per bit.
module afc_sync
   import afc_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // Each bit gets its own chain; only the second flop is read outside.
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic first_stage; // Metastable stage, read only by the second flop.
         logic second_stage; // Settled stage.
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               first_stage <= 1'b0;
               second_stage <= 1'b0;
            end else begin
               first_stage <= async_in[gi];
               second_stage <= first_stage;
            end
         end
         assign sync_out[gi] = second_stage;
      end
   endgenerate

endmodule : afc_sync

// File: testbench/afc_capture_model.sv
`timescale 1ns/1ps
// Back-end capture logic that latches each sample word and its flag on the rising strobe edge.
module afc_capture_model
   import afc_pkg::*;
(
   input wire logic data_valid_strobe,
   input wire logic data_valid_strobe_oe,
   input wire logic [SAMPLE_W-1:0] sample_bus,
   input wire logic sample_bus_oe,
   input wire logic over_range_flag,
   input wire logic over_range_flag_oe,
   output logic [SAMPLE_W-1:0] cap_word,
   output logic cap_flag,
   output logic [15:0] cap_count,
   output logic [15:0] sat_count
);
   logic [SAMPLE_W-1:0] last_word = 12'h000; // Last value actually driven onto the bus.
   logic last_flag = 1'b0; // Last value actually driven onto the flag line.
   logic strobe_line; // Strobe as seen on the wire.

   // Released lines have no keeper, so they drift away from the last driven value.
   always @* begin
      if (sample_bus_oe) begin
         last_word = sample_bus;
      end
      if (over_range_flag_oe) begin
         last_flag = over_range_flag;
      end
      strobe_line = data_valid_strobe_oe ? data_valid_strobe : 1'b0;
   end

   // Counters start clear because this logic has no reset of its own.
   initial begin
      cap_count = 16'h0000;
      sat_count = 16'h0000;
   end

   // Latches on the rising strobe edge and counts saturated words apart.
   always @(posedge strobe_line) begin
      cap_word = sample_bus_oe ? sample_bus : ~last_word;
      cap_flag = over_range_flag_oe ? over_range_flag : ~last_flag;
      cap_count = cap_count + 16'h0001;
      if (cap_flag) begin
         sat_count = sat_count + 16'h0001;
      end
   end
endmodule : afc_capture_model

// File: testbench/tb_adc_output_code_formatter.sv
`timescale 1ns/1ps
// Self-checking bench for the output code formatter with a capture model on its pins.
module tb_adc_output_code_formatter;
   import afc_pkg::*;
   logic ref_clk = 1'b0; // Sample clock, 40 ns period.
   logic link_clk = 1'b0; // Capture-side clock, 12 ns period.
   logic arst_n = 1'b0; // Asynchronous reset, active low.
   logic signed [RAW_W-1:0] raw_value = 13'sh0000; // Converter value fed in.
   logic format_select = 1'b0; // High selects Gray output.
   logic power_down_input = 1'b0; // High releases the outputs.
   logic [SAMPLE_W-1:0] sample_bus;
   logic sample_bus_oe;
   logic over_range_flag;
   logic over_range_flag_oe;
   logic data_valid_strobe;
   logic data_valid_strobe_oe;
   logic [SAMPLE_W-1:0] cap_word;
   logic cap_flag;
   logic [15:0] cap_count;
   logic [15:0] sat_count;
   int n_fail = 0; // Mismatches seen.
   int num_checks = 0; // Comparisons made.
   // Stimulus table: signs, full-scale ends and both over-range sides; it ends in range.
   logic signed [RAW_W-1:0] vals [12] = '{13'sh0000, 13'sh0001, 13'sh0002, -13'sh0001, -13'sh0002, 13'sh07FF,
      13'sh0800, -13'sh0800, -13'sh0801, 13'sh0FFF, -13'sh1000, -13'sh07FF};

   // The sample clock toggles every half period.
   always #20 ref_clk = ~ref_clk;

   // The link clock starts off phase with the sample clock.
   initial begin
      #3;
      forever #6 link_clk = ~link_clk;
   end

   afc_formatter DUT (.ref_clk(ref_clk), .arst_n(arst_n), .link_clk(link_clk), .raw_value(raw_value),
      .format_select(format_select), .power_down_input(power_down_input), .sample_bus(sample_bus),
      .sample_bus_oe(sample_bus_oe), .over_range_flag(over_range_flag), .over_range_flag_oe(over_range_flag_oe),
      .data_valid_strobe(data_valid_strobe), .data_valid_strobe_oe(data_valid_strobe_oe));

   afc_capture_model u_cap (.data_valid_strobe(data_valid_strobe), .data_valid_strobe_oe(data_valid_strobe_oe),
      .sample_bus(sample_bus), .sample_bus_oe(sample_bus_oe), .over_range_flag(over_range_flag),
      .over_range_flag_oe(over_range_flag_oe), .cap_word(cap_word), .cap_flag(cap_flag),
      .cap_count(cap_count), .sat_count(sat_count));

   // Works out flag and word for one raw value; the flag is the top bit.
   function automatic logic [SAMPLE_W:0] expect_code(input logic signed [RAW_W-1:0] v, input logic gray);
      logic ovr;
      logic [SAMPLE_W-1:0] t;
      logic [SAMPLE_W-1:0] o;
      ovr = (v > 13'sh07FF) || (v < -13'sh0800);
      t = ovr ? (v[RAW_W-1] ? 12'h800 : 12'h7FF) : v[SAMPLE_W-1:0];
      o = t ^ 12'h800;
      return {ovr, gray ? (o ^ (o >> 1)) : t};
   endfunction : expect_code

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   // Waits a bounded time for the bus enable to reach the given level.
   task automatic wait_oe(input logic lvl);
      for (int n = 0; n < 20; n++) begin
         @(negedge ref_clk);
         #1;
         if (sample_bus_oe === lvl) begin
            return;
         end
      end
      check(16'h0000, 16'h0001, "output enable timeout");
      end_sim();
   endtask : wait_oe

   // Streams the table back to back and judges each captured word ten falling edges later.
   task automatic run_stream(input logic gray);
      logic [SAMPLE_W:0] exp [12];
      logic [15:0] s0;
      @(negedge ref_clk);
      format_select <= gray;
      repeat (10) @(negedge ref_clk);
      s0 = sat_count;
      for (int k = 0; k < 22; k++) begin
         @(negedge ref_clk);
         if (k < 12) begin
            raw_value <= vals[k];
            exp[k] = expect_code(vals[k], gray);
         end
         #1;
         check({15'h0000, data_valid_strobe}, 16'h0001, "strobe high after fall");
         if (k >= 10) begin
            check({4'h0, cap_word}, {4'h0, exp[k-10][SAMPLE_W-1:0]}, "word");
            check({15'h0000, cap_flag}, {15'h0000, exp[k-10][SAMPLE_W]}, "flag");
         end
      end
      check(sat_count - s0, 16'h0004, "saturated word count");
   endtask : run_stream

   // Enters power-down, checks every pin released and the strobe quiet, then resumes.
   task automatic run_power_down();
      logic [15:0] c0;
      @(negedge ref_clk);
      power_down_input <= 1'b1;
      wait_oe(1'b0);
      check({13'h0000, sample_bus_oe, over_range_flag_oe, data_valid_strobe_oe}, 16'h0000, "released");
      c0 = cap_count;
      repeat (5) @(negedge ref_clk);
      check(cap_count, c0, "strobe edges while released");
      @(negedge ref_clk);
      power_down_input <= 1'b0;
      wait_oe(1'b1);
      check({13'h0000, sample_bus_oe, over_range_flag_oe, data_valid_strobe_oe}, 16'h0007, "driven again");
   endtask : run_power_down

   // Main sequence: reset, both formats, power-down and recovery.
   initial begin
      repeat (10) @(negedge ref_clk);
      #1;
      check({13'h0000, sample_bus_oe, over_range_flag_oe, data_valid_strobe_oe}, 16'h0000, "reset released");
      @(negedge ref_clk);
      arst_n <= 1'b1;
      wait_oe(1'b1);
      run_stream(1'b0);
      run_stream(1'b1);
      run_power_down();
      run_stream(1'b0);
      end_sim();
   end
endmodule : tb_adc_output_code_formatter
